/* File: core/sac_pkg.sv */
// sac_pkg: constants, register map, mode layout and enums of the conversion control
// assumes: included in compile order before sac_core; nothing is imported
package sac_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00; // write-only: reset, start
	localparam logic [7:0] OFS_MODE = 8'h04; // conv_mode_reg
	localparam logic [7:0] OFS_CHEN = 8'h10; // channel_enable_reg, write-only set
	localparam logic [7:0] OFS_CHDIS = 8'h14; // write-only clear
	localparam logic [7:0] OFS_CHSR = 8'h18; // enabled channels
	localparam logic [7:0] OFS_SR = 8'h1C; // conv_status_reg
	localparam logic [7:0] OFS_LAST = 8'h20; // last_result_reg
	localparam logic [7:0] OFS_IEN = 8'h24; // mask set
	localparam logic [7:0] OFS_IDIS = 8'h28; // mask clear
	localparam logic [7:0] OFS_IMASK = 8'h2C; // mask read
	localparam logic [7:0] OFS_CRES0 = 8'h30; // channel_result_reg 0, then every 4
	localparam logic [7:0] OFS_CRES7 = 8'h4C; // channel_result_reg 7
	// control register bits
	localparam int CTRL_SWRST_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	// status register field positions
	localparam int SR_EOC_LSB = 0; // 8 end-of-conversion flags
	localparam int SR_OVR_LSB = 8; // 8 channel_overrun flags
	localparam int SR_RDY_BIT = 16; // result_ready
	localparam int SR_GOVR_BIT = 17; // global_overrun
	localparam int SR_W = 18;
	// reset values
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
	localparam logic [31:0] MODE_WMASK = 32'h0F1F_3F3F; // writable mode bits
	localparam logic [7:0] CHEN_RST = 8'h00;
	localparam logic [SR_W-1:0] SR_RST = 18'h0_0000;
	localparam logic [SR_W-1:0] IMASK_RST = 18'h0_0000;
	// timing counts
	localparam logic [5:0] CONV_BIT_CYCLES = 6'h0A; // converter clocks after sample-hold
	// trigger source codes
	localparam logic [2:0] TRG_TIMER0 = 3'h0;
	localparam logic [2:0] TRG_TIMER1 = 3'h1;
	localparam logic [2:0] TRG_EXT = 3'h6;
	// conv_mode_reg layout, msb first
	typedef struct packed {
		logic [3:0] rsv3;
		logic [3:0] sample_hold_cycles;
		logic [2:0] rsv2;
		logic [4:0] startup;
		logic [1:0] rsv1;
		logic [5:0] conv_clock_divider;
		logic [1:0] rsv0;
		logic sleep;
		logic low_resolution_sel;
		logic [2:0] trigger_source_sel;
		logic hw_trigger_en;
	} sac_mode_s;
	// controls towards the analog cell
	typedef struct packed {
		logic conv_clk; // converter clock
		logic sleep; // cell powered down
		logic sample; // sample-and-hold phase
		logic convert; // bit conversion phase
		logic [2:0] chan; // multiplexer select
	} sac_cell_s;
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAKE = 2'b01,
		ST_CONV = 2'b10
	} sac_state_e;
endpackage : sac_pkg

/* File: core/sac_core.sv */
// sac_core: register file, converter clock, trigger logic and conversion sequencer
// assumes: single clock sys_clk_in, inputs synchronous to it, cell result valid at end
// Overview of operation
// - sample-hold cycles plus ten converter clocks
// - divider zero gives half, 63 gives 1/128
// - eight channels, own result and flags
// - low resolution: upper two data bits zero
// - full resolution after reset
// - transfer width 16 bits, 8 in low res
// - result to channel and last registers
// - completion sets channel end and ready flags
// - ready rising edge issues one transfer request
// - end and ready flags drive masked interrupt
// - channel result read clears its end flag
// - last result read clears ready, last end
// - unread channel rewritten sets channel overrun
// - completion while ready set sets global overrun
// - status read clears all overrun flags
// - start by software, external pin or timers
// - normal keeps clock running, sleep stops it
// - enabled channel routes its pin to converter
// - disabled channel input tied to ground
// - hardware trigger on a rising edge while idle
// - one start converts every enabled channel
// - triggers during a sequence are ignored
// - software start works with hardware triggers on
module sac_core #(
	parameter int NCH = 8, // channel count
	parameter int RES_W = 10 // full resolution
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic [7:0] addr_in, // register byte address
	input wire logic [31:0] wdata_in,
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	output logic [31:0] rdata_out, // valid the cycle after rd_in
	input wire logic ext_trigger_pin_in,
	input wire logic [1:0] timer_output_a_in,
	input wire logic [RES_W-1:0] cell_result_in, // cell conversion value
	output sac_pkg::sac_cell_s cell_ctrl_out,
	output logic [NCH-1:0] chan_route_out, // 1: pin to converter, 0: input grounded
	output logic xfer_req_out, // one-cycle transfer request
	output logic xfer_size16_out, // request width 16 when high, 8 when low
	output logic [15:0] xfer_data_out, // last result for the transfer
	output logic irq_out
);
	// software reset acts like the hardware one
	logic clr;
	assign clr = reset_in | (wr_in && addr_in == sac_pkg::OFS_CTRL &&
		wdata_in[sac_pkg::CTRL_SWRST_BIT]);

	localparam int SR_W_L = sac_pkg::SR_W; // status and mask width
	sac_pkg::sac_mode_s mode_q; // conv_mode_reg
	logic [NCH-1:0] chen_q; // enabled channels
	logic [NCH-1:0] eoc_q; // end of conversion flags
	logic [NCH-1:0] ovr_q; // channel overrun flags
	logic rdy_q; // result_ready
	logic rdy_prev_q; // for edge of result_ready
	logic govr_q; // global overrun
	logic [SR_W_L-1:0] imask_q; // interrupt mask
	logic [RES_W-1:0] cres_q [NCH]; // channel results
	logic [RES_W-1:0] last_q; // last_result_field
	logic [2:0] last_ch_q; // last converted channel
	logic [31:0] rdata_q;
	logic irq_q;

	sac_pkg::sac_state_e state_q;
	logic [5:0] cnt_q; // converter clocks in the phase
	logic [2:0] ch_q; // channel under conversion
	logic [5:0] div_q; // half-period counter
	logic cclk_q; // converter clock level
	logic run_q; // clock kept running after first conversion
	logic trg_prev_q; // selected trigger, last cycle

	// first enabled channel at or above a start index, NCH if none
	function automatic logic [3:0] first_chan(input logic [NCH-1:0] m, input logic [3:0] from);
		logic [3:0] r;
		r = 4'(NCH);
		for (int i = NCH - 1; i >= 0; i--) begin
			if (m[i] && 4'(i) >= from) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : first_chan

	// register decode
	logic rd_sr, rd_last, rd_cres;
	logic [2:0] rd_idx;
	assign rd_sr = rd_in && addr_in == sac_pkg::OFS_SR;
	assign rd_last = rd_in && addr_in == sac_pkg::OFS_LAST;
	assign rd_cres = rd_in && addr_in >= sac_pkg::OFS_CRES0 && addr_in <= sac_pkg::OFS_CRES7
		&& addr_in[1:0] == 2'h0;
	assign rd_idx = 3'((addr_in - sac_pkg::OFS_CRES0) >> 2);

	// selected hardware trigger source
	logic trg_sel;
	always_comb begin
		if (mode_q.trigger_source_sel == sac_pkg::TRG_TIMER0) begin
			trg_sel = timer_output_a_in[0];
		end else if (mode_q.trigger_source_sel == sac_pkg::TRG_TIMER1) begin
			trg_sel = timer_output_a_in[1];
		end else if (mode_q.trigger_source_sel == sac_pkg::TRG_EXT) begin
			trg_sel = ext_trigger_pin_in;
		end else begin
			trg_sel = 1'b0; // reserved codes never trigger
		end
	end

	// start request: software or rising hardware edge
	logic sw_start, hw_start, start, first_ok;
	logic [3:0] first_idx;
	assign sw_start = wr_in && addr_in == sac_pkg::OFS_CTRL
		&& wdata_in[sac_pkg::CTRL_START_BIT];
	assign hw_start = mode_q.hw_trigger_en && trg_sel && !trg_prev_q;
	assign first_idx = first_chan(chen_q, 4'h0);
	assign first_ok = first_idx != 4'(NCH);
	assign start = (sw_start || hw_start) && state_q == sac_pkg::ST_IDLE && first_ok;

	// trigger edge history
	always_ff @(posedge sys_clk_in) begin
		if (clr) begin
			trg_prev_q <= 1'b0;
		end else begin
			trg_prev_q <= trg_sel;
		end
	end

	// converter clock divider; a tick ends each full converter period
	logic clk_en, tick;
	assign clk_en = state_q != sac_pkg::ST_IDLE || (run_q && !mode_q.sleep);
	assign tick = clk_en && cclk_q && div_q == mode_q.conv_clock_divider;
	always_ff @(posedge sys_clk_in) begin
		if (clr || !clk_en || start) begin // a start realigns: whole first period
			div_q <= 6'h00;
			cclk_q <= 1'b0;
		end else if (div_q == mode_q.conv_clock_divider) begin
			div_q <= 6'h00; // half period of div+1 master clocks
			cclk_q <= !cclk_q;
		end else begin
			div_q <= div_q + 6'h01;
		end
	end

	// clock stays on after first conversion in normal mode
	always_ff @(posedge sys_clk_in) begin
		if (clr || mode_q.sleep) begin
			run_q <= 1'b0; // sleep: clock only during a sequence
		end else if (state_q == sac_pkg::ST_CONV) begin
			run_q <= 1'b1;
		end
	end

	// sequencer
	logic done;
	logic [3:0] next_idx;
	assign done = state_q == sac_pkg::ST_CONV && tick
		&& cnt_q == 6'(mode_q.sample_hold_cycles) + sac_pkg::CONV_BIT_CYCLES - 6'h01;
	assign next_idx = first_chan(chen_q, 4'(ch_q) + 4'h1);
	always_ff @(posedge sys_clk_in) begin
		if (clr) begin
			state_q <= sac_pkg::ST_IDLE;
			cnt_q <= 6'h00;
			ch_q <= 3'h0;
		end else begin
			case (state_q)
				sac_pkg::ST_IDLE: begin
					cnt_q <= 6'h00;
					if (start) begin
						ch_q <= first_idx[2:0];
						// a stopped clock needs the cell start-up wait
						state_q <= run_q ? sac_pkg::ST_CONV : sac_pkg::ST_WAKE;
					end
				end
				sac_pkg::ST_WAKE: begin
					if (tick) begin
						if (cnt_q >= 6'(mode_q.startup)) begin
							cnt_q <= 6'h00;
							state_q <= sac_pkg::ST_CONV;
						end else begin
							cnt_q <= cnt_q + 6'h01;
						end
					end
				end
				sac_pkg::ST_CONV: begin
					if (done) begin
						cnt_q <= 6'h00;
						if (next_idx == 4'(NCH)) begin
							state_q <= sac_pkg::ST_IDLE;
						end else begin
							ch_q <= next_idx[2:0];
						end
					end else if (tick) begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
				default: begin
					state_q <= sac_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// result storage, shifted down two bits in low resolution
	logic [RES_W-1:0] res_v;
	assign res_v = mode_q.low_resolution_sel
		? {2'b00, cell_result_in[RES_W-1:2]} : cell_result_in;
	always_ff @(posedge sys_clk_in) begin
		if (clr) begin
			last_q <= '0;
			last_ch_q <= 3'h0;
			for (int i = 0; i < NCH; i++) begin
				cres_q[i] <= '0;
			end
		end else if (done) begin
			cres_q[ch_q] <= res_v;
			last_q <= res_v;
			last_ch_q <= ch_q;
		end
	end

	// per-channel flags; a completion wins over a clearing read
	generate
		for (genvar g = 0; g < NCH; g++) begin : g_flag
			logic hit;
			assign hit = done && ch_q == 3'(g);
			always_ff @(posedge sys_clk_in) begin
				if (clr) begin
					eoc_q[g] <= 1'b0;
					ovr_q[g] <= 1'b0;
				end else begin
					if (hit) begin
						eoc_q[g] <= 1'b1;
					end else if ((rd_cres && rd_idx == 3'(g))
						|| (rd_last && last_ch_q == 3'(g))) begin
						eoc_q[g] <= 1'b0;
					end
					if (hit && eoc_q[g]) begin
						ovr_q[g] <= 1'b1;
					end else if (rd_sr) begin
						ovr_q[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// global flags
	always_ff @(posedge sys_clk_in) begin
		if (clr) begin
			rdy_q <= 1'b0;
			govr_q <= 1'b0;
			rdy_prev_q <= 1'b0;
		end else begin
			rdy_prev_q <= rdy_q;
			if (done) begin
				rdy_q <= 1'b1;
			end else if (rd_last) begin
				rdy_q <= 1'b0;
			end
			if (done && rdy_q) begin
				govr_q <= 1'b1;
			end else if (rd_sr) begin
				govr_q <= 1'b0;
			end
		end
	end

	// status vector
	logic [SR_W_L-1:0] sr_v;
	assign sr_v = {govr_q, rdy_q, ovr_q, eoc_q};

	// software-written registers
	always_ff @(posedge sys_clk_in) begin
		if (clr) begin
			mode_q <= sac_pkg::MODE_RST;
			chen_q <= sac_pkg::CHEN_RST;
			imask_q <= sac_pkg::IMASK_RST;
		end else if (wr_in) begin
			if (addr_in == sac_pkg::OFS_MODE) begin
				mode_q <= wdata_in & sac_pkg::MODE_WMASK;
			end else if (addr_in == sac_pkg::OFS_CHEN) begin
				chen_q <= chen_q | wdata_in[NCH-1:0];
			end else if (addr_in == sac_pkg::OFS_CHDIS) begin
				chen_q <= chen_q & ~wdata_in[NCH-1:0]; // caller avoids mid-conversion
			end else if (addr_in == sac_pkg::OFS_IEN) begin
				imask_q <= imask_q | wdata_in[SR_W_L-1:0];
			end else if (addr_in == sac_pkg::OFS_IDIS) begin
				imask_q <= imask_q & ~wdata_in[SR_W_L-1:0];
			end
		end
	end

	// read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge sys_clk_in) begin
		if (clr) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_in) begin
			if (addr_in == sac_pkg::OFS_MODE) begin
				rdata_q <= mode_q;
			end else if (addr_in == sac_pkg::OFS_CHSR) begin
				rdata_q <= 32'(chen_q);
			end else if (rd_sr) begin
				rdata_q <= 32'(sr_v);
			end else if (rd_last) begin
				rdata_q <= 32'(last_q);
			end else if (addr_in == sac_pkg::OFS_IMASK) begin
				rdata_q <= 32'(imask_q);
			end else if (rd_cres) begin
				rdata_q <= 32'(cres_q[rd_idx]);
			end else begin
				rdata_q <= 32'h0000_0000;
			end
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	// interrupt from masked flags
	always_ff @(posedge sys_clk_in) begin
		if (clr) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(sr_v & imask_q);
		end
	end

	// outputs
	assign rdata_out = rdata_q;
	assign irq_out = irq_q;
	assign chan_route_out = chen_q;
	assign xfer_req_out = rdy_q && !rdy_prev_q;
	assign xfer_size16_out = !mode_q.low_resolution_sel;
	assign xfer_data_out = 16'(last_q);
	assign cell_ctrl_out.conv_clk = cclk_q;
	assign cell_ctrl_out.sleep = !clk_en;
	assign cell_ctrl_out.sample = state_q == sac_pkg::ST_CONV
		&& cnt_q < 6'(mode_q.sample_hold_cycles);
	assign cell_ctrl_out.convert = state_q == sac_pkg::ST_CONV
		&& cnt_q >= 6'(mode_q.sample_hold_cycles);
	assign cell_ctrl_out.chan = ch_q;

	// assertion helpers: master cycles between ticks, master cycles in a conversion
	logic [7:0] gap_q;
	logic gap_ok_q;
	logic [11:0] tcnt_q;
	always_ff @(posedge sys_clk_in) begin
		// realigned or reprogrammed clock gives one irregular period
		if (clr || !clk_en || start || (wr_in && addr_in == sac_pkg::OFS_MODE)) begin
			gap_q <= 8'h00;
			gap_ok_q <= 1'b0;
		end else if (tick) begin
			gap_q <= 8'h01;
			gap_ok_q <= 1'b1;
		end else begin
			gap_q <= gap_q + 8'h01;
		end
		if (clr || state_q != sac_pkg::ST_CONV || done) begin
			tcnt_q <= 12'h000;
		end else begin
			tcnt_q <= tcnt_q + 12'h001; // master cycles, independent of the tick count
		end
	end

	sequence s_complete;
		done ##1 1'b1;
	endsequence
	sequence s_fresh_ready;
		done && !rdy_q;
	endsequence

	conv_length_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		done |-> tcnt_q + 12'h001 == 12'((int'(mode_q.sample_hold_cycles)
			+ int'(sac_pkg::CONV_BIT_CYCLES)) * 2 * (int'(mode_q.conv_clock_divider) + 1)))
		else $error("conversion length wrong");
	clk_period_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		tick && gap_ok_q |-> gap_q == 8'(2 * (int'(mode_q.conv_clock_divider) + 1)))
		else $error("converter clock period wrong");
	low_res_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		done && mode_q.low_resolution_sel |=> last_q[RES_W-1:RES_W-2] == 2'b00)
		else $error("low resolution upper bits set");
	flags_set_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		s_complete |-> rdy_q && eoc_q[$past(ch_q)] && last_q == cres_q[$past(ch_q)])
		else $error("completion flags or results missing");
	xfer_req_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		s_fresh_ready |=> xfer_req_out ##1 !xfer_req_out)
		else $error("transfer request not single");
	irq_path_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		$rose(rdy_q) && imask_q[sac_pkg::SR_RDY_BIT] |=> irq_out)
		else $error("ready interrupt missing");
	last_read_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		rd_last && !done |=> !rdy_q && !eoc_q[$past(last_ch_q)])
		else $error("last read did not clear");
	chan_ovr_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		done && eoc_q[ch_q] |=> ovr_q[$past(ch_q)])
		else $error("channel overrun missed");
	glob_ovr_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		done && rdy_q |=> govr_q)
		else $error("global overrun missed");
	sr_clear_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		rd_sr && !done |=> ovr_q == '0 && !govr_q)
		else $error("status read left overrun");
	busy_ignore_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		state_q == sac_pkg::ST_CONV && !done |=> state_q == sac_pkg::ST_CONV
			&& ch_q == $past(ch_q))
		else $error("trigger disturbed sequence");
	sleep_stop_a: assert property (@(posedge sys_clk_in) disable iff (clr)
		mode_q.sleep && state_q == sac_pkg::ST_IDLE |-> cell_ctrl_out.sleep ##1 !cclk_q)
		else $error("sleep clock not stopped");
endmodule : sac_core

/* File: tb/sac_cell_model.sv */
// sac_cell_model: behavioural analog cell plus a counter of transfer requests
// assumes: fed by the control outputs of sac_core on the same master clock
module sac_cell_model (
	input wire logic sys_clk_in,
	input wire sac_pkg::sac_cell_s cell_ctrl_in,
	input wire logic xfer_req_in,
	output logic [9:0] cell_result_out,
	output int xfer_count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_q; // one cycle of hold after the last phase
	logic [9:0] val; // value of the selected channel
	// value depends on the channel so a wrong select shows
	assign val = 10'h305 + 10'(cell_ctrl_in.chan) * 10'h13;
	// outside a conversion the cell shows the inverse, never a stale value
	assign cell_result_out = (cell_ctrl_in.sample | cell_ctrl_in.convert | busy_q) ? val : ~val;
	// hold tracker
	always_ff @(posedge sys_clk_in) begin
		busy_q <= cell_ctrl_in.sample | cell_ctrl_in.convert;
	end
	// transfer controller side: count requests
	int req_cnt = 0; // requests seen
	always @(posedge sys_clk_in) begin
		if (xfer_req_in === 1'b1) req_cnt <= req_cnt + 1;
	end
	assign xfer_count_out = req_cnt;
endmodule : sac_cell_model

/* File: tb/sac_core_test.sv */
// sac_core_test: self-checking bench of the conversion control
// assumes: sac_pkg and sac_core compiled first, cell model in its own file
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module sac_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0; // master clock
	logic rst = 1'b1; // synchronous reset
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0; // write strobe
	logic rd = 1'b0; // read strobe
	logic ext = 1'b0; // external trigger pin
	logic [1:0] tmr = 2'h0; // timer outputs
	logic [31:0] rdata;
	logic [9:0] cres;
	sac_pkg::sac_cell_s ctrl;
	logic [7:0] route;
	logic xreq, xsz, irq;
	logic [15:0] xdata;
	int xcnt, miscompares = 0, total_checks = 0;
	int s_run = 0, c_run = 0, s_len = 0, c_len = 0, convs = 0; // phase monitor
	logic [31:0] d; // last read word
	always #5 clk = ~clk;
	sac_core u_sac_core (.sys_clk_in(clk), .reset_in(rst), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ext_trigger_pin_in(ext),
		.timer_output_a_in(tmr), .cell_result_in(cres), .cell_ctrl_out(ctrl),
		.chan_route_out(route), .xfer_req_out(xreq), .xfer_size16_out(xsz),
		.xfer_data_out(xdata), .irq_out(irq));
	sac_cell_model u_sac_cell_model (.sys_clk_in(clk), .cell_ctrl_in(ctrl), .xfer_req_in(xreq),
		.cell_result_out(cres), .xfer_count_out(xcnt));
	// measures phase lengths in master cycles and counts finished conversions
	always @(posedge clk) begin
		if (ctrl.sample === 1'b1) s_run++;
		else if (s_run > 0) begin s_len = s_run; s_run = 0; end
		if (ctrl.convert === 1'b1) c_run++;
		else if (c_run > 0) begin c_len = c_run; c_run = 0; convs++; end
	end
	function automatic logic [9:0] cv(input int ch);
		return 10'h305 + 10'(ch) * 10'h13;
	endfunction : cv
	function automatic logic [31:0] md(input int dv, sh, lr, sl, te, src);
		sac_pkg::sac_mode_s m;
		m = '0;
		m.conv_clock_divider = 6'(dv);
		m.sample_hold_cycles = 4'(sh);
		m.low_resolution_sel = 1'(lr);
		m.sleep = 1'(sl);
		m.hw_trigger_en = 1'(te);
		m.trigger_source_sel = 3'(src);
		return m;
	endfunction : md
	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a; wdata <= v; wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		addr <= a; rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	// waits until n more conversions finished, then lets flags land
	task automatic wconv(input int n);
		int t, goal;
		t = 0;
		goal = convs + n;
		while (convs < goal && t < 20000) begin @(posedge clk); t++; end
		`CHK("conv done", 1'b1, convs >= goal)
		repeat (8) @(posedge clk);
	endtask : wconv
	task automatic t_reset();
		rreg(sac_pkg::OFS_MODE); `CHK("mode", 32'h0, d)
		rreg(sac_pkg::OFS_CHSR); `CHK("chsr", 32'h0, d)
		rreg(sac_pkg::OFS_SR); `CHK("sr", 32'h0, d)
		rreg(8'h08); `CHK("unmapped", 32'h0, d)
		`CHK("route", 8'h00, route)
		`CHK("clk stopped", 1'b1, ctrl.sleep)
		$display("test reset done");
	endtask : t_reset
	// phase lengths for divider boundaries and a middle value
	task automatic t_timing();
		int dv[3] = '{0, 2, 63};
		int sh[3] = '{1, 3, 1};
		wreg(sac_pkg::OFS_CHEN, 32'h1);
		for (int i = 0; i < 3; i++) begin
			wreg(sac_pkg::OFS_MODE, md(dv[i], sh[i], 0, 0, 0, 0));
			wreg(sac_pkg::OFS_CTRL, 32'h2);
			wconv(1);
			`CHK("sample len", sh[i] * 2 * (dv[i] + 1), s_len)
			`CHK("convert len", 10 * 2 * (dv[i] + 1), c_len)
			rreg(sac_pkg::OFS_LAST); `CHK("last", {22'h0, cv(0)}, d)
		end
		`CHK("clk runs", 1'b0, ctrl.sleep)
		$display("test timing done");
	endtask : t_timing
	task automatic t_seq();
		int x;
		x = xcnt;
		wreg(sac_pkg::OFS_CHEN, 32'h84); // adds channels 2, 7; channel 0 stays enabled
		rreg(sac_pkg::OFS_CHSR); `CHK("chsr", 32'h85, d)
		`CHK("route", 8'h85, route)
		wreg(sac_pkg::OFS_MODE, md(0, 1, 0, 0, 0, 0));
		wreg(sac_pkg::OFS_IEN, 32'h10000);
		wreg(sac_pkg::OFS_CTRL, 32'h2);
		wconv(3);
		`CHK("xfer once", x + 1, xcnt)
		`CHK("xfer data", {6'h0, cv(7)}, xdata)
		`CHK("size16", 1'b1, xsz)
		`CHK("irq", 1'b1, irq)
		rreg(sac_pkg::OFS_SR); `CHK("sr", 32'h30085, d)
		rreg(sac_pkg::OFS_SR); `CHK("sr clr", 32'h10085, d)
		rreg(sac_pkg::OFS_CRES0 + 8'h08); `CHK("res2", {22'h0, cv(2)}, d)
		rreg(sac_pkg::OFS_CRES0); `CHK("res0", {22'h0, cv(0)}, d)
		rreg(sac_pkg::OFS_SR); `CHK("sr eoc", 32'h10080, d)
		rreg(sac_pkg::OFS_LAST); `CHK("last", {22'h0, cv(7)}, d)
		rreg(sac_pkg::OFS_SR); `CHK("sr last", 32'h0, d)
		`CHK("irq off", 1'b0, irq)
		wreg(sac_pkg::OFS_IDIS, 32'h10000);
		rreg(sac_pkg::OFS_IMASK); `CHK("imask", 32'h0, d)
		$display("test sequence done");
	endtask : t_seq
	task automatic t_ovr();
		int x, n;
		x = xcnt;
		n = convs;
		wreg(sac_pkg::OFS_CRES0 + 8'h08, 32'h0); // read-only place, ignored
		wreg(sac_pkg::OFS_CTRL, 32'h2);
		wreg(sac_pkg::OFS_CTRL, 32'h2); // dropped while busy
		wconv(3);
		repeat (300) @(posedge clk);
		`CHK("no extra", 1'b0, ctrl.convert)
		`CHK("conv count", n + 3, convs)
		`CHK("xfer once", x + 1, xcnt)
		wreg(sac_pkg::OFS_CTRL, 32'h2); // every result still unread
		wconv(3);
		`CHK("xfer held", x + 1, xcnt)
		rreg(sac_pkg::OFS_SR); `CHK("sr ovr", 32'h38585, d)
		rreg(sac_pkg::OFS_SR); `CHK("sr clr", 32'h10085, d)
		for (int c = 0; c < 8; c++) rreg(sac_pkg::OFS_CRES0 + 8'(4 * c));
		rreg(sac_pkg::OFS_LAST);
		$display("test overrun done");
	endtask : t_ovr
	task automatic t_low_resolution_sel();
		wreg(sac_pkg::OFS_CHDIS, 32'h84); // channels idle here
		wreg(sac_pkg::OFS_MODE, md(0, 1, 1, 0, 0, 0));
		wreg(sac_pkg::OFS_CTRL, 32'h2);
		wconv(1);
		`CHK("size8", 1'b0, xsz)
		rreg(sac_pkg::OFS_CRES0); `CHK("res lo", {22'h0, cv(0) >> 2}, d)
		rreg(sac_pkg::OFS_LAST); `CHK("last lo", {22'h0, cv(0) >> 2}, d)
		$display("test low resolution done");
	endtask : t_low_resolution_sel
	task automatic t_trig();
		int src[3] = '{6, 0, 1};
		int n;
		for (int i = 0; i < 3; i++) begin
			wreg(sac_pkg::OFS_MODE, md(0, 1, 0, 0, 1, src[i]));
			n = convs;
			@(posedge clk);
			{ext, tmr} <= 3'b111 ^ (i == 0 ? 3'b100 : 3'(i)); // wrong sources rise first
			repeat (300) @(posedge clk);
			`CHK("wrong src", n, convs)
			{ext, tmr} <= 3'b111;
			wconv(1);
			repeat (300) @(posedge clk);
			`CHK("one edge", n + 1, convs)
			{ext, tmr} <= 3'b000;
			wreg(sac_pkg::OFS_CTRL, 32'h2);
			wconv(1);
			rreg(sac_pkg::OFS_LAST);
		end
		$display("test triggers done");
	endtask : t_trig
	task automatic t_sleep();
		wreg(sac_pkg::OFS_MODE, md(0, 1, 0, 1, 0, 0));
		wreg(sac_pkg::OFS_CTRL, 32'h2);
		wconv(1);
		`CHK("sleep", 1'b1, ctrl.sleep)
		wreg(sac_pkg::OFS_CTRL, 32'h1);
		rreg(sac_pkg::OFS_MODE); `CHK("swrst mode", 32'h0, d)
		rreg(sac_pkg::OFS_CHSR); `CHK("swrst chsr", 32'h0, d)
		$display("test sleep done");
	endtask : t_sleep
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_timing();
		t_seq();
		t_ovr();
		t_low_resolution_sel();
		t_trig();
		t_sleep();
		end_of_test();
	end
	// watchdog
	initial begin
		#900000;
		miscompares++;
		end_of_test();
	end
endmodule : sac_core_test
